// File: sync_slave_defines.vh
// register offsets, field positions, reset values for the sync slave port
// assumes: included by the port files, 32-bit AXI4-Lite data, byte addresses
`ifndef SYNC_SLAVE_DEFINES_VH
`define SYNC_SLAVE_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_INTCTL   8'h00
`define OFF_FLAGS    8'h04
`define OFF_ENABLES  8'h08
`define OFF_PRIO     8'h0C
`define OFF_RXSTAT   8'h10
`define OFF_TXBUF    8'h14
`define OFF_TXSTAT   8'h18
`define OFF_BAUD     8'h1C
`define OFF_RXBUF    8'h20
`define OFF_SLEEP    8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define B_GIE     7
`define B_PEIE    6
`define B_RECEIVE_COMPLETE_FLAG    5
`define B_TRANSMIT_BUFFER_EMPTY_FLAG    4
`define B_SERIAL_PORT_ENABLE    7
`define B_RX9     6
`define B_SINGLE_RECEIVE_ENABLE    5
`define B_CONTINUOUS_RECEIVE_ENABLE    4
`define B_FRAMING_ERROR_FLAG    2
`define B_OVERRUN_ERROR_FLAG    1
`define B_RECEIVED_NINTH_BIT    0
`define B_CLOCK_SOURCE_SELECT    7
`define B_TX9     6
`define B_TRANSMIT_ENABLE    5
`define B_SYNC    4
`define B_SHIFT_REGISTER_EMPTY    1
`define B_TRANSMIT_NINTH_BIT    0

// ----------------------------------------------------------------
// reset values and the txstat write mask
// ----------------------------------------------------------------
`define RST_PRIO    8'hFF
`define RST_TXSTAT  8'h02
`define RST_ZERO    8'h00
`define TXSTAT_WMASK 8'hFD

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// File: sync_slave_shifter.v
// shift engine of the slave port: transmit and receive on the link clock
// assumes: sclkSync already two-flop synchronised to clk; data pin too
`default_nettype none

module sync_slave_shifter #(
    parameter WORD = 9
) (
    input  wire            clk,
    input  wire            rst,
    input  wire            sclkSync,
    input  wire            dataSync,
    input  wire            active,
    input  wire            txOn,
    input  wire            rxOn,
    input  wire            nineTx,
    input  wire            nineRx,
    input  wire [WORD-1:0] loadWord,
    input  wire            loadStb,
    output reg             shiftEmpty,
    output reg             dataOut,
    output reg             dataOe,
    output reg  [WORD-1:0] rxWord,
    output reg             rxDone
);

    // ----------------------------------------------------------------
    // edge detection on the synchronised shift clock
    // ----------------------------------------------------------------
    reg            sclkLast_reg;
    reg [WORD-1:0] txShift_reg;
    reg [3:0]      txLeft_reg;
    reg [WORD-1:0] rxShift_reg;
    reg [3:0]      rxCount_reg;
    wire           rise = sclkSync & ~sclkLast_reg;
    wire           fall = ~sclkSync & sclkLast_reg;
    wire [3:0]     txLen = nineTx ? 4'h9 : 4'h8;
    wire [3:0]     rxLen = nineRx ? 4'h9 : 4'h8;

    always @(posedge clk) begin
        if (rst) begin
            sclkLast_reg <= 1'b0;
            txShift_reg  <= {WORD{1'b0}};
            txLeft_reg   <= 4'h0;
            rxShift_reg  <= {WORD{1'b0}};
            rxCount_reg  <= 4'h0;
            shiftEmpty   <= 1'b1;
            dataOut      <= 1'b0;
            dataOe       <= 1'b0;
            rxWord       <= {WORD{1'b0}};
            rxDone       <= 1'b0;
        end else begin
            sclkLast_reg <= sclkSync;
            rxDone       <= 1'b0;
            dataOe       <= active & txOn;
            if (loadStb) begin
                // lsb goes out first, presented at once
                txShift_reg <= loadWord >> 1;
                dataOut     <= loadWord[0];
                txLeft_reg  <= txLen;
                shiftEmpty  <= 1'b0;
            end else if (rise && txLeft_reg != 4'h0) begin
                // next bit changes on the rising edge of the shift clock
                txLeft_reg  <= txLeft_reg - 4'h1;
                txShift_reg <= txShift_reg >> 1;
                dataOut     <= txShift_reg[0];
                if (txLeft_reg == 4'h1) begin
                    shiftEmpty <= 1'b1;
                end
            end
            if (!(active && rxOn)) begin
                rxCount_reg <= 4'h0;
            end else if (fall) begin
                // sampled on the falling edge, lsb first
                if (rxCount_reg + 4'h1 == rxLen) begin
                    rxCount_reg <= 4'h0;
                    rxDone      <= 1'b1;
                    rxWord      <= nineRx ?
                                   {dataSync, rxShift_reg[WORD-1:1]} :
                                   {1'b0, dataSync, rxShift_reg[WORD-1:2]};
                end else begin
                    rxCount_reg <= rxCount_reg + 4'h1;
                end
                rxShift_reg <= {dataSync, rxShift_reg[WORD-1:1]};
            end
        end
    end

endmodule

`default_nettype wire

// File: sync_serial_slave_port.v
// synchronous serial slave port: registers, buffers, flags, interrupt
// assumes: AXI4-Lite master on clk; link clock and data come from pins
`default_nettype none
`include "sync_slave_defines.vh"

module sync_serial_slave_port (
    input  wire        clk,
    input  wire        rst,
    input  wire        sclkPin,
    input  wire        dataIn,
    output reg         dataOut,
    output reg         dataOe,
    output reg         irq,
    output reg         wake,
    output reg         vectorReq,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] sclkSyn_reg;
    reg [1:0] dataSyn_reg;

    always @(posedge clk) begin
        if (rst) begin
            sclkSyn_reg <= 2'b00;
            dataSyn_reg <= 2'b00;
        end else begin
            // only the second stage is read below
            sclkSyn_reg <= {sclkSyn_reg[0], sclkPin};
            dataSyn_reg <= {dataSyn_reg[0], dataIn};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] intCtl_reg;
    reg [7:0] enables_reg;
    reg [7:0] prio_reg;
    reg [7:0] rxCtl_reg;
    reg [7:0] txBuf_reg;
    reg [7:0] txCtl_reg;
    reg [7:0] baud_reg;
    reg [7:0] rxBuf_reg;
    reg       rxNinth_reg;
    reg       overrun_error_flag_reg;
    reg       sleep_reg;
    reg       txFull_reg;
    reg       txNinth_reg;
    reg       transmit_buffer_empty_flag_reg;
    reg       receive_complete_flag_reg;

    wire       portOn = rxCtl_reg[`B_SERIAL_PORT_ENABLE] & txCtl_reg[`B_SYNC];
    // only slave mode is built; a set clock source select halts shifting
    wire       active = portOn & ~txCtl_reg[`B_CLOCK_SOURCE_SELECT];
    wire       txOn = txCtl_reg[`B_TRANSMIT_ENABLE];
    // only continuous enable gates reception here
    wire       rxOn = rxCtl_reg[`B_CONTINUOUS_RECEIVE_ENABLE];
    wire       shiftEmpty;
    wire [8:0] rxWord;
    wire       rxDone;
    wire       loadStb = active & txOn & txFull_reg & shiftEmpty;

    // ----------------------------------------------------------------
    // shifters
    // ----------------------------------------------------------------
    wire dOut;
    wire dOe;

    sync_slave_shifter #(
        .WORD (9)
    ) u_shift (
        .clk        (clk),
        .rst        (rst),
        .sclkSync   (sclkSyn_reg[1]),
        .dataSync   (dataSyn_reg[1]),
        .active     (active),
        .txOn       (txOn),
        .rxOn       (rxOn),
        .nineTx     (txCtl_reg[`B_TX9]),
        .nineRx     (rxCtl_reg[`B_RX9]),
        .loadWord   ({txNinth_reg, txBuf_reg}),
        .loadStb    (loadStb),
        .shiftEmpty (shiftEmpty),
        .dataOut    (dOut),
        .dataOe     (dOe),
        .rxWord     (rxWord),
        .rxDone     (rxDone)
    );

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    reg        awHeld_reg;
    reg        wHeld_reg;
    reg [7:0]  awAddr_reg;
    reg [7:0]  wData_reg;
    wire       doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    wire       doRead = s_axi_arvalid & s_axi_arready;
    wire [7:0] rdAddr = s_axi_araddr;

    function known;
        input [7:0] a;
        begin
            known = (a[1:0] == 2'b00) && (a <= `OFF_SLEEP);
        end
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 8'h00;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg    <= 1'b1;
                awAddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg    <= 1'b1;
                // only byte lane 0 carries register data
                wData_reg    <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(awAddr_reg) ? `RESP_OKAY
                                                  : `RESP_SLVERR;
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (doRead) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= known(rdAddr) ? `RESP_OKAY : `RESP_SLVERR;
                case (rdAddr)
                    `OFF_INTCTL:  s_axi_rdata <= {24'h00_0000, intCtl_reg};
                    `OFF_FLAGS:   s_axi_rdata <= {24'h00_0000, 2'b00,
                                      receive_complete_flag_reg, transmit_buffer_empty_flag_reg, 4'h0};
                    `OFF_ENABLES: s_axi_rdata <= {24'h00_0000, enables_reg};
                    `OFF_PRIO:    s_axi_rdata <= {24'h00_0000, prio_reg};
                    `OFF_RXSTAT:  s_axi_rdata <= {24'h00_0000,
                                      rxCtl_reg[7:3], 1'b0, overrun_error_flag_reg,
                                      rxNinth_reg};
                    `OFF_TXBUF:   s_axi_rdata <= {24'h00_0000, txBuf_reg};
                    `OFF_TXSTAT:  s_axi_rdata <= {24'h00_0000,
                                      txCtl_reg[7:4], 1'b0, txCtl_reg[2],
                                      shiftEmpty, txNinth_reg};
                    `OFF_BAUD:    s_axi_rdata <= {24'h00_0000, baud_reg};
                    `OFF_RXBUF:   s_axi_rdata <= {24'h00_0000, rxBuf_reg};
                    `OFF_SLEEP:   s_axi_rdata <= {31'h0000_0000, sleep_reg};
                    default:      s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes, buffers and flags
    // ----------------------------------------------------------------
    wire wrTxBuf = doWrite && awAddr_reg == `OFF_TXBUF;
    wire wrRxCtl = doWrite && awAddr_reg == `OFF_RXSTAT;
    wire irqNext = (transmit_buffer_empty_flag_reg & enables_reg[`B_TRANSMIT_BUFFER_EMPTY_FLAG])
                 | (receive_complete_flag_reg & enables_reg[`B_RECEIVE_COMPLETE_FLAG]);

    always @(posedge clk) begin
        if (rst) begin
            intCtl_reg  <= `RST_ZERO;
            enables_reg <= `RST_ZERO;
            prio_reg    <= `RST_PRIO;
            rxCtl_reg   <= `RST_ZERO;
            txBuf_reg   <= `RST_ZERO;
            txCtl_reg   <= `RST_TXSTAT;
            baud_reg    <= `RST_ZERO;
            rxBuf_reg   <= `RST_ZERO;
            rxNinth_reg <= 1'b0;
            overrun_error_flag_reg    <= 1'b0;
            sleep_reg   <= 1'b0;
            txFull_reg  <= 1'b0;
            txNinth_reg <= 1'b0;
            transmit_buffer_empty_flag_reg    <= 1'b0;
            receive_complete_flag_reg    <= 1'b0;
        end else begin
            if (doWrite) begin
                case (awAddr_reg)
                    `OFF_INTCTL:  intCtl_reg  <= wData_reg;
                    `OFF_ENABLES: enables_reg <= wData_reg;
                    `OFF_PRIO:    prio_reg    <= wData_reg;
                    `OFF_RXSTAT:  rxCtl_reg   <= wData_reg & 8'hF8;
                    `OFF_TXSTAT:  txCtl_reg   <= wData_reg & `TXSTAT_WMASK;
                    `OFF_BAUD:    baud_reg    <= wData_reg;
                    `OFF_SLEEP:   sleep_reg   <= wData_reg[0];
                    default:      ;
                endcase
                if (awAddr_reg == `OFF_TXSTAT) begin
                    txNinth_reg <= wData_reg[`B_TRANSMIT_NINTH_BIT];
                end
            end
            // buffer empty flag: software cannot clear it, a write does
            if (wrTxBuf) begin
                txBuf_reg  <= wData_reg;
                txFull_reg <= 1'b1;
                transmit_buffer_empty_flag_reg   <= 1'b0;
            end else if (loadStb) begin
                // word moves to the shifter, flag sets that cycle
                txFull_reg <= 1'b0;
                transmit_buffer_empty_flag_reg   <= 1'b1;
            end
            if (wrRxCtl && !wData_reg[`B_CONTINUOUS_RECEIVE_ENABLE]) begin
                overrun_error_flag_reg <= 1'b0;
            end
            // a word arriving while the buffer is unread is an overrun
            if (rxDone) begin
                if (receive_complete_flag_reg) begin
                    overrun_error_flag_reg <= 1'b1;
                end else begin
                    rxBuf_reg   <= rxWord[7:0];
                    rxNinth_reg <= rxWord[8];
                    receive_complete_flag_reg    <= 1'b1;
                end
            end else if (doRead && rdAddr == `OFF_RXBUF) begin
                receive_complete_flag_reg <= 1'b0;
            end
            // an enabled interrupt ends sleep
            if (irqNext) begin
                sleep_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt, wake and outputs
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            irq       <= 1'b0;
            wake      <= 1'b0;
            vectorReq <= 1'b0;
            dataOut   <= 1'b0;
            dataOe    <= 1'b0;
        end else begin
            irq       <= irqNext;
            wake      <= irqNext & sleep_reg;
            vectorReq <= irqNext & intCtl_reg[`B_GIE]
                       & intCtl_reg[`B_PEIE];
            dataOut   <= dOut;
            dataOe    <= dOe;
        end
    end

endmodule

`default_nettype wire

// File: sync_serial_slave_port_chk.sv
// checker for the sync slave port: bus handshake and interrupt relations
// assumes: bound to sync_serial_slave_port, one clock, synchronous reset
`default_nettype none
module sync_serial_slave_port_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sclkPin,
    input wire logic        dataOut,
    input wire logic        dataOe,
    input wire logic        irq,
    input wire logic        wake,
    input wire logic        vectorReq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ------------------------------------------------------------
    // cycles since bus or link activity, saturating at 15
    // ------------------------------------------------------------
    logic [3:0] busCnt;
    logic [3:0] linkCnt;
    logic       sclkQ;
    wire        busHs = (s_axi_awvalid && s_axi_awready) ||
                        (s_axi_wvalid && s_axi_wready) ||
                        (s_axi_arvalid && s_axi_arready);
    always_ff @(posedge clk) begin
        sclkQ <= sclkPin;
        if (rst || busHs) busCnt <= 4'h0;
        else if (busCnt != 4'hF) busCnt <= busCnt + 4'h1;
        if (rst || busHs || sclkQ != sclkPin) linkCnt <= 4'h0;
        else if (linkCnt != 4'hF) linkCnt <= linkCnt + 4'h1;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    reset_state_a: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> s_axi_awready && s_axi_wready && s_axi_arready
            && !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("bus or irq not idle after reset");
    rd_answer_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    rd_hold_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    wr_hold_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response dropped before bready");
    wake_irq_a: assert property (
        @(posedge clk) disable iff (rst) wake |-> irq)
        else $error("wake without interrupt");
    vector_irq_a: assert property (
        @(posedge clk) disable iff (rst) vectorReq |-> irq)
        else $error("vector request without interrupt");
    irq_rise_a: assert property (
        @(posedge clk) disable iff (rst) $rose(irq) |-> linkCnt < 4'hC)
        else $error("interrupt rose with no link or bus cause");
    irq_drop_a: assert property (
        @(posedge clk) disable iff (rst) $fell(irq) |-> busCnt < 4'h6)
        else $error("interrupt fell with no register access");
    tx_edge_a: assert property (
        @(posedge clk) disable iff (rst)
        dataOe && $past(dataOe) && $changed(dataOut) |-> linkCnt < 4'h8)
        else $error("data pin moved without a link clock edge");
endmodule
bind sync_serial_slave_port sync_serial_slave_port_chk i_chk (
    .clk, .rst, .sclkPin, .dataOut, .dataOe, .irq, .wake, .vectorReq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: sync_link_master.sv
// model of the external synchronous master that drives the shift clock
// assumes: the bench calls frame between transfers; clock idles low
`default_nettype none
module sync_link_master (
    output logic      sclkPin,
    output logic      dataIn,
    input  wire logic dataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    parameter HALF = 100;
    initial begin
        sclkPin = 1'b0;
        dataIn = 1'b1;
    end
    // clock only runs inside a frame; data held a full half period past
    // the falling edge so the synchroniser lag cannot lose it
    task automatic frame(input logic [8:0] tx, input int n,
                         output logic [8:0] rx);
        int i;
        rx = 9'h000;
        #7;
        for (i = 0; i < n; i++) begin
            rx[i] = dataOut;
            dataIn = tx[i];
            sclkPin = 1'b1;
            #HALF;
            sclkPin = 1'b0;
            #HALF;
        end
        dataIn = ~dataIn;
    endtask
endmodule
`default_nettype wire

// File: sync_serial_slave_port_bench.sv
// testbench for the sync slave port: registers, link words, interrupts
// assumes: sync_link_master model and the design files are compiled
`default_nettype none
`include "sync_slave_defines.vh"
module sync_serial_slave_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         sclkPin, dataIn, dataOut, dataOe, irq, wake, vectorReq;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          errTotal = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    logic        sawWake = 1'b0;
    logic [1:0]  resp;
    logic [8:0]  got;
    sync_serial_slave_port i_dut (.clk, .rst, .sclkPin, .dataIn, .dataOut,
        .dataOe, .irq, .wake, .vectorReq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sync_link_master i_mst (.sclkPin, .dataIn, .dataOut);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // wake may last one cycle only, so it is latched here
    always @(posedge wake) sawWake <= 1'b1;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errTotal++;
            wrap_up;
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, e);
        samplesChecked++;
        if (seen !== e) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) check("write answer", 32'h0, 32'h1);
    endtask
    task automatic rdChk(input string what, input logic [7:0] a,
                         input logic [31:0] m, e);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                check(what, s_axi_rdata & m, e);
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) check("read answer", 32'h0, 32'h1);
    endtask
    task automatic waitIrq(input logic v);
        int n;
        for (n = 0; n < 40 && irq !== v; n++) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testRegs;
        rdChk("prio", `OFF_PRIO, 32'hFF, 32'hFF);
        rdChk("txstat", `OFF_TXSTAT, 32'hFF, 32'h02);
        rdChk("flags", `OFF_FLAGS, 32'hFF, 32'h00);
        wr(`OFF_TXSTAT, 32'h0);
        rdChk("shift_register_empty kept", `OFF_TXSTAT, 32'hFF, 32'h02);
        wr(`OFF_FLAGS, 32'hFF);
        rdChk("flags kept", `OFF_FLAGS, 32'hFF, 32'h00);
        wr(8'h40, 32'h0);
        check("unmapped", 32'(resp), 32'(`RESP_SLVERR));
        $display("register test done");
    endtask
    task automatic testTxSleep;
        wr(`OFF_RXSTAT, 32'h80);
        wr(`OFF_TXSTAT, 32'h30);
        wr(`OFF_ENABLES, 32'h10);
        wr(`OFF_INTCTL, 32'hC0);
        wr(`OFF_TXBUF, 32'hA5);
        wr(`OFF_TXBUF, 32'h3C);
        sawWake = 1'b0;
        wr(`OFF_SLEEP, 32'h1);
        rdChk("transmit_buffer_empty_flag held", `OFF_FLAGS, 32'h10, 32'h0);
        rdChk("shifter busy", `OFF_TXSTAT, 32'h02, 32'h0);
        check("irq quiet", 32'(irq), 32'h0);
        check("data drive", 32'(dataOe), 32'h1);
        i_mst.frame(9'h000, 8, got);
        check("first word", 32'(got), 32'hA5);
        waitIrq(1'b1);
        check("vector", 32'(vectorReq), 32'h1);
        check("woke", 32'(sawWake), 32'h1);
        rdChk("transmit_buffer_empty_flag set", `OFF_FLAGS, 32'h10, 32'h10);
        i_mst.frame(9'h000, 8, got);
        check("second word", 32'(got), 32'h3C);
        rdChk("shifter idle", `OFF_TXSTAT, 32'h02, 32'h02);
        wr(`OFF_ENABLES, 32'h0);
        waitIrq(1'b0);
        check("irq masked", 32'(irq), 32'h0);
        wr(`OFF_TXSTAT, 32'h71);
        wr(`OFF_TXBUF, 32'h5A);
        i_mst.frame(9'h000, 9, got);
        check("nine bit word", 32'(got), 32'h15A);
        wr(`OFF_TXSTAT, 32'h10);
        $display("transmit test done");
    endtask
    task automatic testRx;
        wr(`OFF_ENABLES, 32'h20);
        wr(`OFF_RXSTAT, 32'hB0);
        check("data released", 32'(dataOe), 32'h0);
        sawWake = 1'b0;
        wr(`OFF_SLEEP, 32'h1);
        i_mst.frame(9'h0C3, 8, got);
        waitIrq(1'b1);
        check("rx irq", 32'(irq), 32'h1);
        check("rx woke", 32'(sawWake), 32'h1);
        rdChk("no errors", `OFF_RXSTAT, 32'h07, 32'h0);
        rdChk("rx word", `OFF_RXBUF, 32'hFF, 32'hC3);
        waitIrq(1'b0);
        check("rx irq clear", 32'(irq), 32'h0);
        wr(`OFF_RXSTAT, 32'hD0);
        i_mst.frame(9'h196, 9, got);
        waitIrq(1'b1);
        rdChk("ninth bit", `OFF_RXSTAT, 32'h01, 32'h01);
        rdChk("rx nine", `OFF_RXBUF, 32'hFF, 32'h96);
        $display("receive test done");
    endtask
    task automatic testOverrun;
        wr(`OFF_ENABLES, 32'h0);
        wr(`OFF_RXSTAT, 32'h90);
        i_mst.frame(9'h011, 8, got);
        i_mst.frame(9'h022, 8, got);
        rdChk("receive_complete_flag", `OFF_FLAGS, 32'h20, 32'h20);
        check("irq masked", 32'(irq), 32'h0);
        rdChk("overrun", `OFF_RXSTAT, 32'h02, 32'h02);
        wr(`OFF_RXSTAT, 32'h80);
        rdChk("overrun clear", `OFF_RXSTAT, 32'h02, 32'h0);
        rdChk("kept word", `OFF_RXBUF, 32'hFF, 32'h11);
        wr(`OFF_RXSTAT, 32'hA0);
        i_mst.frame(9'h055, 8, got);
        rdChk("single enable", `OFF_FLAGS, 32'h20, 32'h0);
        $display("overrun test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        testRegs;
        testTxSleep;
        testRx;
        testOverrun;
        wrap_up;
    end
endmodule
`default_nettype wire
